// ===== bench/adccs_assertions.sv
/* Checker on the ports of adccs_top.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
module adccs_assertions
  import adccs_pkg::*;
#(parameter int CONV_CYC = 13) (
  // Watched ports
  input wire logic       CLK, ARST_N, DIFF_MODE, START_WR,
  input wire adccs_sel_t POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT,
  input wire adccs_sel_t MUX_POS, MUX_NEG,
  input wire logic       SAMPLING, START_CONVERSION_CMD, RESULT_READY_FLAG
);
  localparam int LASTC = CONV_CYC - 1;
  // Single domain, so one clocking for all
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  AST_START:
  assert property (START_WR && !START_CONVERSION_CMD && !SAMPLING
    |=> START_CONVERSION_CMD ##1 SAMPLING) else $error("start late");
  AST_CAUSE:
  assert property ($rose(SAMPLING) |-> $past(START_CONVERSION_CMD))
    else $error("start without command");
  AST_LEN:
  assert property ($rose(SAMPLING) |-> ##LASTC SAMPLING
    ##1 (RESULT_READY_FLAG && !SAMPLING)) else $error("bad length");
  AST_FLAG:
  assert property ($rose(RESULT_READY_FLAG) && !$past(START_WR)
    |-> !START_CONVERSION_CMD)
    else $error("command not cleared");
  AST_FREEZE:
  assert property (SAMPLING |-> $stable(MUX_POS) && $stable(MUX_NEG))
    else $error("selection moved");
  AST_TRACK:
  assert property (!SAMPLING && !START_CONVERSION_CMD
    |=> MUX_POS == $past(POSITIVE_INPUT_SELECT)) else $error("no track");
  AST_LAST:
  assert property ($fell(SAMPLING)
    |-> MUX_POS == $past(POSITIVE_INPUT_SELECT)) else $error("no resume");
  AST_NEG:
  assert property (!SAMPLING && !START_CONVERSION_CMD
    |=> MUX_NEG == (DIFF_MODE ? $past(NEGATIVE_INPUT_SELECT) : '0))
    else $error("neg lost");
endmodule
bind adccs_top adccs_assertions #(.CONV_CYC(CONV_CYC)) i_chk (.CLK, .ARST_N,
  .DIFF_MODE, .START_WR, .POSITIVE_INPUT_SELECT, .NEGATIVE_INPUT_SELECT,
  .MUX_POS, .MUX_NEG, .SAMPLING, .START_CONVERSION_CMD, .RESULT_READY_FLAG);

// ===== bench/adccs_top_test.sv
/* Self-checking bench for adccs_top.
   Assumes the design files are compiled before it. */
`timescale 1ns/1ps
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t mismatch", $time); end
module adccs_top_test
  import adccs_pkg::*;
;
  logic clk = 0, arst_n = 0, diff = 0, sgn = 0, go = 0, clr = 0;
  logic smp, cmd, rdy;
  logic [7:0] cnt = 0;
  logic [15:0] res, exp_v;
  adccs_sel_t pos = 0, neg = 0, mpos, mneg;
  int fail_count = 0, n_tests = 0, i;
  // Rows: diff, signed, count, expected result for one negative sum
  logic [25:0] rows [5] = '{{2'b01, 8'h20, 16'h91a3},
    {2'b11, 8'h40, 16'h48d1}, {2'b01, 8'h80, 16'h2468},
    {2'b10, 8'h20, 16'h2346}, {2'b01, 8'h10, 16'h2346}};
  // Short conversion keeps the run brief
  adccs_top #(.CONV_CYC(4)) i_dut (.CLK(clk), .ARST_N(arst_n),
    .POSITIVE_INPUT_SELECT(pos), .NEGATIVE_INPUT_SELECT(neg),
    .DIFF_MODE(diff), .SIGNED_MODE(sgn), .SAMPLE_COUNT(cnt),
    .START_WR(go), .FLAG_CLR(clr), .ACC_IN(24'hf12346), .MUX_POS(mpos),
    .MUX_NEG(mneg), .SAMPLING(smp), .START_CONVERSION_CMD(cmd),
    .RESULT_READY_FLAG(rdy), .RESULT(res));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  // Verdict in one place
  task report_and_stop;
    $display("tests %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog, far beyond the expected run of about 80 cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop;
  end
  // Row loop, then reset in mid-conversion
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      {diff, sgn, cnt, exp_v} <= rows[i];
      pos <= 7'h01 + i[6:0];
      neg <= 7'h11;
      @(posedge clk) go <= 1;
      @(posedge clk) go <= 0;
      repeat (3) @(posedge clk);
      pos <= 7'h55;
      #1 `CHK(mpos, 7'h01 + i[6:0])
      while (rdy !== 1'b1) @(negedge clk);
      `CHK(res, exp_v)
      `CHK(mpos, 7'h55)
      `CHK(mneg, diff ? 7'h11 : 7'h00)
      `CHK(cmd, 1'b0)
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
      $display("row %0d done", i);
    end
    // Start taken, then a write in the final cycle wins over the clear
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
    #1 `CHK({cmd, smp}, 2'b10)
    repeat (4) @(posedge clk);
    go <= 1;
    @(posedge clk) go <= 0;
    #1 `CHK({cmd, rdy, smp}, 3'b110)
    @(posedge clk) clr <= 1;
    @(posedge clk) clr <= 0;
    #1 `CHK({rdy, smp}, 2'b01)
    // Clear in the completion cycle loses to the set
    repeat (2) @(posedge clk);
    clr <= 1;
    @(posedge clk) clr <= 0;
    #1 `CHK({rdy, cmd, smp}, 3'b100)
    $display("back to back done");
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
    repeat (2) @(posedge clk);
    arst_n <= 0;
    #1 `CHK({smp, cmd, rdy, res, mpos, mneg}, '0)
    // Start at the first edge after release; holder tracks again
    @(posedge clk) begin
      arst_n <= 1;
      go     <= 1;
    end
    @(posedge clk) go <= 0;
    #1 `CHK({cmd, smp, mpos}, {2'b10, 7'h55})
    @(posedge clk);
    #1 `CHK(smp, 1'b1)
    $display("reset done");
    report_and_stop;
  end
endmodule

// ===== rtl/adccs_hold.sv
/*
  Holding register for the input selections.
  Assumes written selections are synchronous to CLK.
*/
`timescale 1ns/1ps
module adccs_hold
  import adccs_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  arst_n,
  // Written selections
  input  wire adccs_sel_t wr_pos,
  input  wire adccs_sel_t wr_neg,
  // Held side
  adccs_sel_if.hold  sel
);
  adccs_sel_t pos_r;
  adccs_sel_t neg_r;

  // Follow writes while tracking, else freeze
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_r <= `ADCCS_SEL_RST;
      neg_r <= `ADCCS_SEL_RST;
    end else if (sel.track) begin
      pos_r <= wr_pos;
      neg_r <= wr_neg;
    end
  end

  assign sel.pos = pos_r;
  assign sel.neg = neg_r;
endmodule

// ===== rtl/adccs_map.svh
/*
  Constants for the converter channel select and start block.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef ADCCS_MAP_SVH
`define ADCCS_MAP_SVH
`define ADCCS_SEL_W       7
`define ADCCS_SEL_RST     7'h00
`define ADCCS_CONV_CYC    13
`define ADCCS_RES_W       16
`define ADCCS_ACC_W       24
`define ADCCS_TRUNC_SH    3'h1
`define ADCCS_SH_64       3'h2
`define ADCCS_SH_128      3'h3
`define ADCCS_SH_NONE     3'h0
`define ADCCS_CNT_32      8'h20
`define ADCCS_CNT_64      8'h40
`define ADCCS_CNT_128     8'h80
`endif

// ===== rtl/adccs_pkg.sv
/*
  Types for the converter channel select and start block.
  Assumes the map header is on the include path.
*/
`include "adccs_map.svh"
package adccs_pkg;
  typedef logic [`ADCCS_SEL_W-1:0] adccs_sel_t;
  typedef enum logic [1:0] {ADCCS_IDLE, ADCCS_CONV, ADCCS_LAST} adccs_state_e;
endpackage

// ===== rtl/adccs_sel_if.sv
/*
  Interface carrying the held selections between the top and the holder.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface adccs_sel_if;
  import adccs_pkg::*;
  adccs_sel_t pos;
  adccs_sel_t neg;
  logic       track;
  modport ctl (output track, input pos, input neg);
  modport hold (input track, output pos, output neg);
endinterface

// ===== rtl/adccs_top.sv
/*
  Converter channel select, start sequencing and result format.
  Assumes CLK is the converter clock and that the analog core
  delivers a raw accumulated value on ACC_IN by the final cycle.
*/
`timescale 1ns/1ps
module adccs_top
  import adccs_pkg::*;
#(
  parameter int CONV_CYC = `ADCCS_CONV_CYC
) (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  // Software controls
  input  wire adccs_sel_t              POSITIVE_INPUT_SELECT,
  input  wire adccs_sel_t              NEGATIVE_INPUT_SELECT,
  input  wire logic                    DIFF_MODE,
  input  wire logic                    SIGNED_MODE,
  input  wire logic [7:0]              SAMPLE_COUNT,
  input  wire logic                    START_WR,
  input  wire logic                    FLAG_CLR,
  // Raw accumulation from the analog core
  input  wire logic [`ADCCS_ACC_W-1:0] ACC_IN,
  // Analog mux drive
  output adccs_sel_t                   MUX_POS,
  output adccs_sel_t                   MUX_NEG,
  output logic                         SAMPLING,
  // Status
  output logic                         START_CONVERSION_CMD,
  output logic                         RESULT_READY_FLAG,
  output logic [`ADCCS_RES_W-1:0]      RESULT
);
  // Held selections travel between here and the holder on this bundle
  adccs_sel_if             sel ();

  // Sequencer state and its next value
  adccs_state_e            state_r;
  adccs_state_e            state_nxt;

  // Busy-cycle count and its next value
  logic [7:0]              cnt_r;
  logic [7:0]              cnt_nxt;

  // Start command bit, software visible
  logic                    cmd_r;
  logic                    cmd_nxt;

  // Sticky result-ready flag
  logic                    flag_r;
  logic                    flag_nxt;

  // Result word, loaded once per conversion
  logic [`ADCCS_RES_W-1:0] res_r;
  logic [`ADCCS_RES_W-1:0] res_nxt;

  // Count at which the busy phase hands over to the final cycle;
  // below two cycles the final cycle would overlap the start
  localparam logic [7:0] CONV_END = 8'(CONV_CYC - 2);

  // Shift that reduces a big accumulation to 16 bits
  function automatic logic [2:0] trunc_shift(input logic [7:0] n);
    case (n)
      `ADCCS_CNT_32: begin
        trunc_shift = `ADCCS_TRUNC_SH;
      end
      `ADCCS_CNT_64: begin
        trunc_shift = `ADCCS_SH_64;
      end
      `ADCCS_CNT_128: begin
        trunc_shift = `ADCCS_SH_128;
      end
      default: begin
        trunc_shift = `ADCCS_SH_NONE;
      end
    endcase
  endfunction

  // State decode, shared by the sequencer and the holder control
  wire in_idle  = (state_r == ADCCS_IDLE);
  wire in_conv  = (state_r == ADCCS_CONV);
  wire last_cyc = (state_r == ADCCS_LAST);
  wire conv_end = in_conv && (cnt_r == CONV_END);

  // Completion is the final cycle itself
  wire done     = last_cyc;

  // A pending command starts the next edge
  wire begin_cv = in_idle && cmd_r;

  // Result format: only the large signed counts are truncated
  wire [2:0] shift   = trunc_shift(SAMPLE_COUNT);
  wire       big_acc = SIGNED_MODE && (shift != `ADCCS_SH_NONE);

  // Arithmetic shift keeps the sign of a negative sum
  wire signed [`ADCCS_ACC_W-1:0] acc_s  = ACC_IN;
  wire signed [`ADCCS_ACC_W-1:0] acc_sh = acc_s >>> shift;

  // Low 16 bits of the shifted or raw sum; upper bits are dropped
  wire [`ADCCS_RES_W-1:0] res_val = big_acc ?
       acc_sh[`ADCCS_RES_W-1:0] :
       ACC_IN[`ADCCS_RES_W-1:0];

  // Track while idle with no start pending, and again in the final
  // cycle; a pending start stops tracking so the start edge locks
  assign sel.track = (in_idle && !cmd_r) ||
                     last_cyc;

  // Holder: the only path from the written selects to the mux
  adccs_hold u_hold (
    .clk    (CLK),
    .arst_n (ARST_N),
    .wr_pos (POSITIVE_INPUT_SELECT),
    .wr_neg (NEGATIVE_INPUT_SELECT),
    .sel    (sel.hold)
  );

  // Next state of the conversion sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCCS_IDLE: begin
        if (begin_cv) begin
          state_nxt = ADCCS_CONV;
        end
      end
      ADCCS_CONV: begin
        if (conv_end) begin
          state_nxt = ADCCS_LAST;
        end
      end
      ADCCS_LAST: begin
        state_nxt = ADCCS_IDLE;
      end
      default: begin
        state_nxt = ADCCS_IDLE;
      end
    endcase
  end

  // Counter runs only while busy, so it restarts at zero each time
  assign cnt_nxt = in_conv ? cnt_r + 8'h01 : 8'h00;

  // Command: a write in the final cycle wins over the completion
  // clear, so a start issued right at the end is not lost
  assign cmd_nxt = START_WR ? 1'b1 :
                   done     ? 1'b0 :
                   cmd_r;

  // Flag: a set wins over a clear in the same cycle
  assign flag_nxt = done     ? 1'b1 :
                    FLAG_CLR ? 1'b0 :
                    flag_r;

  // Result is loaded only at completion and held after
  assign res_nxt = done ? res_val : res_r;

  // Sequencer and cycle counter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= ADCCS_IDLE;
      cnt_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Command bit
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // Ready flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Result word
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  // Positive select always reaches the mux
  assign MUX_POS = sel.pos;

  // Negative select is only meaningful in differential mode
  assign MUX_NEG = DIFF_MODE ? sel.neg : `ADCCS_SEL_RST;

  // Busy covers the whole conversion, final cycle included
  assign SAMPLING = !in_idle;

  // Status straight from flip-flops
  assign START_CONVERSION_CMD = cmd_r;
  assign RESULT_READY_FLAG    = flag_r;
  assign RESULT               = res_r;
endmodule
